// [byte_sync_consts.svh]
`ifndef BYTE_SYNC_CONSTS_SVH
`define BYTE_SYNC_CONSTS_SVH

// Register byte addresses
`define ADDR_CMD 8'h00
`define ADDR_MODE 8'h04
`define ADDR_XMIT 8'h08
`define ADDR_SYNC_LO 8'h0C
`define ADDR_SYNC_HI 8'h10
`define ADDR_LEN_PRESET 8'h14
`define ADDR_EXT 8'h18
`define ADDR_TXDATA 8'h1C
`define ADDR_STATUS 8'h20

// Reset values
`define MODE_CFG_RST 8'h00
`define XMIT_CTL_RST 8'h00
`define SYNC_LO_RST 8'h00
`define SYNC_HI_RST 8'h00
`define LEN_PRESET_RST 8'h00
`define EXT_CTL_RST 8'h00
`define CRC_RST 16'h0000

// mode_config fields
`define MODE_PAR_EN 0
`define MODE_PAR_EVEN 1
`define MODE_STOP_LO 2
`define MODE_STOP_HI 3
`define MODE_SYNC_LO 4
`define MODE_SYNC_HI 5
`define MODE_CF_LO 6
`define MODE_CF_HI 7

// transmit_control fields
`define XMIT_CRC_EN 0
`define XMIT_POLY16 2
`define XMIT_EN 3
`define XMIT_BPC_LO 5
`define XMIT_BPC_HI 6
`define BPC_FIVE 2'h0
`define BPC_SEVEN 2'h1
`define BPC_SIX 2'h2
`define BPC_EIGHT 2'h3

// sync_length_crc_preset, extended_control, command_register fields
`define LEN_SYNC6 0
`define LEN_CRC_PRESET 7
`define EXT_FIFO_LEVEL 5
`define CMD_CODE_LO 6
`define CMD_CODE_HI 7
`define CMD_RESET_TX_CRC 2'h2

// CRC polynomials
`define POLY_CRC16 16'h8005
`define POLY_CCITT 16'h1021

// Transmit FIFO
`define TX_FIFO_DEPTH 4
`define TX_PTR_W 2
`define TX_FIFO_FULL 3'h4

`endif

// [byte_sync_pkg.sv]
`include "byte_sync_consts.svh"

package byte_sync_pkg;

    typedef enum logic [1:0] {K_IDLE, K_SYNC, K_DATA} kind_t;

    typedef struct packed {
        logic [7:0] mode_cfg;
        logic [7:0] xmit_ctl;
        logic [7:0] sync_lo;
        logic [7:0] sync_hi;
        logic [7:0] len_preset;
        logic [7:0] ext_ctl;
        logic [`TX_FIFO_DEPTH-1:0][7:0] fifo_mem;
        logic [`TX_PTR_W-1:0] wr_ptr;
        logic [`TX_PTR_W-1:0] rd_ptr;
        logic [`TX_PTR_W:0] fifo_cnt;
        logic txc_s1;
        logic txc_s2;
        logic txc_s3;
        kind_t kind;
        logic [15:0] sh;
        logic [4:0] cnt;
        logic [3:0] data_left;
        logic crc_on;
        logic [15:0] crc;
        logic txd;
        logic [31:0] prdata;
    } state_t;

endpackage : byte_sync_pkg

// [byte_sync_transmitter.sv]
`timescale 1ns/10ps
`include "byte_sync_consts.svh"

module byte_sync_transmitter import byte_sync_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial line
    input wire logic txc,
    output logic txd,
    // Buffer service request
    output logic tx_buf_req
);

    state_t st_ff;
    state_t nxt_st;

    logic sync_mode;
    logic ext_sync;
    logic [1:0] eff_cf;
    logic run_ok;
    logic tick;
    logic reload;
    logic wr_acc;
    logic push;
    logic pop;
    logic preset_cmd;
    logic [4:0] sync_len;
    logic [15:0] sync_frame;
    logic [7:0] head;
    logic [3:0] dlen;
    logic [15:0] dbits;
    logic par_bit;
    logic [15:0] data_frame;
    logic [4:0] data_len;
    logic [15:0] poly;
    logic [31:0] rd_word;
    kind_t cur_kind;
    logic [15:0] cur_sh;
    logic [4:0] cur_cnt;
    logic [3:0] cur_dl;
    logic cur_crc;

    function automatic logic addr_ok(input logic [7:0] a);
        case (a)
            `ADDR_CMD, `ADDR_MODE, `ADDR_XMIT, `ADDR_SYNC_LO, `ADDR_SYNC_HI,
            `ADDR_LEN_PRESET, `ADDR_EXT, `ADDR_TXDATA, `ADDR_STATUS: addr_ok = 1'h1;
            default: addr_ok = 1'h0;
        endcase
    endfunction : addr_ok

    // Five-bit setting: leading ones and a zero marker frame 1..5 bits
    function automatic logic [3:0] char_len(input logic [1:0] bpc, input logic [7:0] d);
        case (bpc)
            `BPC_EIGHT: char_len = 4'h8;
            `BPC_SEVEN: char_len = 4'h7;
            `BPC_SIX: char_len = 4'h6;
            default: begin
                if (d[7:4] == 4'hF) begin
                    char_len = 4'h1;
                end else if (d[7:5] == 3'h7) begin
                    char_len = 4'h2;
                end else if (d[7:6] == 2'h3) begin
                    char_len = 4'h3;
                end else if (d[7]) begin
                    char_len = 4'h4;
                end else begin
                    char_len = 4'h5;
                end
            end
        endcase
    endfunction : char_len

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b,
                                             input logic [15:0] p);
        logic fb;
        fb = c[15] ^ b;
        crc_step = {c[14:0], 1'h0} ^ (fb ? p : 16'h0000);
    endfunction : crc_step

    // Configuration decode
    assign sync_mode = (st_ff.mode_cfg[`MODE_STOP_HI:`MODE_STOP_LO] == 2'h0);
    assign ext_sync = st_ff.mode_cfg[`MODE_SYNC_HI] & st_ff.mode_cfg[`MODE_SYNC_LO];
    // Only the 1x clock factor is served; internal sync forces it, other factors idle the line under external sync
    assign eff_cf = (sync_mode && !ext_sync) ? 2'h0
                    : st_ff.mode_cfg[`MODE_CF_HI:`MODE_CF_LO];
    assign run_ok = sync_mode && (eff_cf == 2'h0) && st_ff.xmit_ctl[`XMIT_EN];
    assign poly = st_ff.xmit_ctl[`XMIT_POLY16] ? `POLY_CRC16 : `POLY_CCITT;

    // Sync pattern, right-justified, low register first on the line
    always_comb begin
        if (!ext_sync && st_ff.mode_cfg[`MODE_SYNC_LO]
                && !st_ff.len_preset[`LEN_SYNC6]) begin
            sync_len = 5'h10;
            sync_frame = {st_ff.sync_hi, st_ff.sync_lo};
        end else if (st_ff.len_preset[`LEN_SYNC6]) begin
            // The twelve-bit receive code falls back to six bits here
            sync_len = 5'h06;
            sync_frame = {10'h000, st_ff.sync_lo[5:0]};
        end else begin
            sync_len = 5'h08;
            sync_frame = {8'h00, st_ff.sync_lo};
        end
    end

    // Data character framing from the FIFO head
    assign head = st_ff.fifo_mem[st_ff.rd_ptr];
    assign dlen = char_len(st_ff.xmit_ctl[`XMIT_BPC_HI:`XMIT_BPC_LO], head);
    assign dbits = {8'h00, head} & ((16'h0001 << dlen) - 16'h0001);
    assign par_bit = st_ff.mode_cfg[`MODE_PAR_EVEN] ? (^dbits) : ~(^dbits);
    assign data_frame = dbits | (st_ff.mode_cfg[`MODE_PAR_EN]
                                 ? (16'(par_bit) << dlen) : 16'h0000);
    assign data_len = 5'(dlen) + 5'(st_ff.mode_cfg[`MODE_PAR_EN]);

    // Falling edge of the synchronised link clock
    assign tick = !st_ff.txc_s2 && st_ff.txc_s3;
    assign reload = (st_ff.cnt == 5'h00);

    assign wr_acc = psel && penable && pwrite && pstrb[0];
    assign rd_word = {st_ff.crc, 7'h00, st_ff.kind == K_DATA, eff_cf, ext_sync,
                      sync_mode, tx_buf_req, st_ff.fifo_cnt};

    always_comb begin
        nxt_st = st_ff;
        push = 1'h0;
        pop = 1'h0;
        preset_cmd = 1'h0;
        cur_kind = st_ff.kind;
        cur_sh = st_ff.sh;
        cur_cnt = st_ff.cnt;
        cur_dl = st_ff.data_left;
        cur_crc = st_ff.crc_on;

        nxt_st.txc_s1 = txc;
        nxt_st.txc_s2 = st_ff.txc_s1;
        nxt_st.txc_s3 = st_ff.txc_s2;

        // Read data is fetched in the setup cycle, so access never waits
        if (psel && !penable) begin
            nxt_st.prdata = (!pwrite && paddr == `ADDR_STATUS) ? rd_word : 32'h0000_0000;
        end

        if (wr_acc) begin
            case (paddr)
                `ADDR_CMD: begin
                    preset_cmd = (pwdata[`CMD_CODE_HI:`CMD_CODE_LO]
                                  == `CMD_RESET_TX_CRC);
                end
                `ADDR_MODE: nxt_st.mode_cfg = pwdata[7:0];
                `ADDR_XMIT: nxt_st.xmit_ctl = pwdata[7:0];
                `ADDR_SYNC_LO: nxt_st.sync_lo = pwdata[7:0];
                `ADDR_SYNC_HI: nxt_st.sync_hi = pwdata[7:0];
                `ADDR_LEN_PRESET: nxt_st.len_preset = pwdata[7:0];
                `ADDR_EXT: nxt_st.ext_ctl = pwdata[7:0];
                `ADDR_TXDATA: begin
                    // A write to a full FIFO is dropped
                    if (st_ff.fifo_cnt != `TX_FIFO_FULL) begin
                        push = 1'h1;
                        nxt_st.fifo_mem[st_ff.wr_ptr] = pwdata[7:0];
                        nxt_st.wr_ptr = st_ff.wr_ptr + `TX_PTR_W'(1);
                    end
                end
                default: begin
                end
            endcase
        end

        if (tick) begin
            if (reload) begin
                if (!run_ok) begin
                    cur_kind = K_IDLE;
                end else if (st_ff.fifo_cnt != 3'h0) begin
                    cur_kind = K_DATA;
                end else begin
                    cur_kind = K_SYNC;
                end
                case (cur_kind)
                    K_DATA: begin
                        pop = 1'h1;
                        nxt_st.rd_ptr = st_ff.rd_ptr + `TX_PTR_W'(1);
                        cur_sh = data_frame;
                        cur_cnt = data_len;
                        cur_dl = dlen;
                        cur_crc = st_ff.xmit_ctl[`XMIT_CRC_EN];
                    end
                    K_SYNC: begin
                        cur_sh = sync_frame;
                        cur_cnt = sync_len;
                        cur_dl = 4'h0;
                        cur_crc = 1'h0;
                    end
                    default: begin
                        // Marking line, one bit at a time
                        cur_sh = 16'hFFFF;
                        cur_cnt = 5'h01;
                        cur_dl = 4'h0;
                        cur_crc = 1'h0;
                    end
                endcase
            end
            nxt_st.kind = cur_kind;
            nxt_st.crc_on = cur_crc;
            nxt_st.txd = cur_sh[0];
            nxt_st.sh = cur_sh >> 1;
            nxt_st.cnt = cur_cnt - 5'h01;
            if (cur_dl != 4'h0) begin
                nxt_st.data_left = cur_dl - 4'h1;
                if (cur_crc) begin
                    nxt_st.crc = crc_step(st_ff.crc, cur_sh[0], poly);
                end
            end else begin
                nxt_st.data_left = 4'h0;
            end
        end

        // Preset overrides a bit accumulated in the same cycle
        if (preset_cmd) begin
            nxt_st.crc = {16{st_ff.len_preset[`LEN_CRC_PRESET]}};
        end

        case ({push, pop})
            2'h2: nxt_st.fifo_cnt = st_ff.fifo_cnt + 3'h1;
            2'h1: nxt_st.fifo_cnt = st_ff.fifo_cnt - 3'h1;
            default: nxt_st.fifo_cnt = st_ff.fifo_cnt;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.mode_cfg <= `MODE_CFG_RST;
            st_ff.xmit_ctl <= `XMIT_CTL_RST;
            st_ff.sync_lo <= `SYNC_LO_RST;
            st_ff.sync_hi <= `SYNC_HI_RST;
            st_ff.len_preset <= `LEN_PRESET_RST;
            st_ff.ext_ctl <= `EXT_CTL_RST;
            st_ff.crc <= `CRC_RST;
            st_ff.txd <= 1'h1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !addr_ok(paddr);
    assign txd = st_ff.txd;
    // Level flag: any free entry, or only a completely empty FIFO
    assign tx_buf_req = st_ff.ext_ctl[`EXT_FIFO_LEVEL]
                        ? (st_ff.fifo_cnt != `TX_FIFO_FULL)
                        : (st_ff.fifo_cnt == 3'h0);

    property p_sync6;
        @(posedge pclk) disable iff (!presetn)
        (tick && reload && run_ok && st_ff.fifo_cnt == 3'h0 && sync_len == 5'h06)
        |=> (st_ff.cnt == 5'h05 && st_ff.txd == $past(st_ff.sync_lo[0])
             && st_ff.kind == K_SYNC);
    endproperty
    a_sync6: assert property (p_sync6) else $error("six-bit sync load wrong");

    property p_sync8;
        @(posedge pclk) disable iff (!presetn)
        (tick && reload && run_ok && st_ff.fifo_cnt == 3'h0
         && !st_ff.len_preset[`LEN_SYNC6] && !st_ff.mode_cfg[`MODE_SYNC_LO])
        |=> (st_ff.cnt == 5'h07 && st_ff.sh[6:0] == $past(st_ff.sync_lo[7:1]));
    endproperty
    a_sync8: assert property (p_sync8) else $error("eight-bit sync load wrong");

    property p_sync16;
        @(posedge pclk) disable iff (!presetn)
        (tick && reload && run_ok && st_ff.fifo_cnt == 3'h0 && !ext_sync
         && st_ff.mode_cfg[`MODE_SYNC_LO] && !st_ff.len_preset[`LEN_SYNC6])
        |=> (st_ff.cnt == 5'h0F && st_ff.sh[14:7] == $past(st_ff.sync_hi));
    endproperty
    a_sync16: assert property (p_sync16) else $error("sixteen-bit sync load wrong");

    property p_ext_len;
        @(posedge pclk) disable iff (!presetn)
        (tick && reload && run_ok && st_ff.fifo_cnt == 3'h0 && ext_sync)
        |=> (st_ff.cnt == ($past(st_ff.len_preset[`LEN_SYNC6]) ? 5'h05 : 5'h07));
    endproperty
    a_ext_len: assert property (p_ext_len) else $error("external sync length wrong");

    property p_async_idle;
        @(posedge pclk) disable iff (!presetn)
        (tick && reload && !sync_mode) |=> (st_ff.txd && st_ff.kind == K_IDLE);
    endproperty
    a_async_idle: assert property (p_async_idle) else $error("line not idle");

    property p_clk_factor;
        @(posedge pclk) disable iff (!presetn)
        (sync_mode && !ext_sync) |-> (eff_cf == 2'h0 && rd_word[7:6] == 2'h0);
    endproperty
    a_clk_factor: assert property (p_clk_factor) else $error("clock factor not forced");

    property p_crc_preset;
        @(posedge pclk) disable iff (!presetn)
        preset_cmd |=> (st_ff.crc == {16{$past(st_ff.len_preset[`LEN_CRC_PRESET])}});
    endproperty
    a_crc_preset: assert property (p_crc_preset) else $error("CRC preset wrong");

    property p_crc_hold;
        @(posedge pclk) disable iff (!presetn)
        (tick && !reload && !st_ff.crc_on && !preset_cmd) |=> $stable(st_ff.crc);
    endproperty
    a_crc_hold: assert property (p_crc_hold) else $error("CRC moved while off");

    property p_sync_no_crc;
        @(posedge pclk) disable iff (!presetn)
        (tick && reload && run_ok && st_ff.fifo_cnt == 3'h0)
        |=> (!st_ff.crc_on && st_ff.data_left == 4'h0);
    endproperty
    a_sync_no_crc: assert property (p_sync_no_crc) else $error("sync in CRC");

    property p_crc_sample;
        @(posedge pclk) disable iff (!presetn)
        (tick && reload && run_ok && st_ff.fifo_cnt != 3'h0)
        |=> (st_ff.crc_on == $past(st_ff.xmit_ctl[`XMIT_CRC_EN]) && st_ff.kind == K_DATA);
    endproperty
    a_crc_sample: assert property (p_crc_sample) else $error("CRC enable not sampled");

    property p_empty_req;
        @(posedge pclk) disable iff (!presetn)
        (!st_ff.ext_ctl[`EXT_FIFO_LEVEL] && st_ff.fifo_cnt != 3'h0) |-> !tx_buf_req;
    endproperty
    a_empty_req: assert property (p_empty_req) else $error("request before empty");

    property p_back_to_back;
        @(posedge pclk) disable iff (!presetn)
        (tick && reload && run_ok) |=> (st_ff.kind != K_IDLE);
    endproperty
    a_back_to_back: assert property (p_back_to_back) else $error("gap between chars");

    property p_lsb_first;
        @(posedge pclk) disable iff (!presetn)
        (tick && reload && run_ok && st_ff.fifo_cnt != 3'h0)
        |=> (st_ff.txd == $past(st_ff.fifo_mem[st_ff.rd_ptr][0]));
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("first bit not LSB");

endmodule : byte_sync_transmitter

// [line_rx.sv]
`timescale 1ns/10ps

module line_rx (
    // Serial line
    input wire logic txd,
    output logic txc
);
    logic bits [0:4095];
    int n;

    // Modem clock runs free: an idle sync line still carries fill characters
    initial begin
        txc = 1'b1;
        n = 0;
        #37;
        forever #100 txc = ~txc;
    end

    // Sample at the falling edge, before txd may move for the next bit
    always @(negedge txc) begin
        if (n < 4096) begin
            bits[n] = txd;
            n = n + 1;
        end
    end
endmodule : line_rx

// [testbench.sv]
`timescale 1ns/10ps
`include "byte_sync_consts.svh"

module testbench import byte_sync_pkg::*; ;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txc, txd, tx_buf_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    int errors, checks, cyc, st;

    byte_sync_transmitter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txc(txc), .txd(txd), .tx_buf_req(tx_buf_req));
    line_rx rx (.txd(txd), .txc(txc));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task wrap_up;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // Generous ceiling: the whole sequence needs about 16000 cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            $display("ERROR %0t: timeout", $time);
            wrap_up;
        end
    end

    task apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q,
             output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task rd(input logic [7:0] a);
        logic e;
        apb(1'b0, a, 8'h00, r, e);
    endtask : rd

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Search the captured line for a bit run, first bit in time at pat[0]
    task look(input logic [63:0] pat, input int len);
        logic hit, ok;
        hit = 1'b0;
        wait (rx.n >= st + 96);
        for (int i = st; i + len <= rx.n; i++) begin
            ok = 1'b1;
            for (int j = 0; j < len; j++) if (rx.bits[i + j] !== pat[j]) ok = 1'b0;
            if (ok) hit = 1'b1;
        end
        chk({31'h0, hit}, 32'h1);
    endtask : look

    function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d,
                                         input logic [15:0] p);
        for (int i = 0; i < 8; i++) c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ p) : {c[14:0], 1'b0};
        return c;
    endfunction : crc8

    task t_reset;
        logic e;
        chk(txd, 1'b1);
        chk(tx_buf_req, 1'b1);
        rd(`ADDR_STATUS);
        chk(r, 32'h00000018);
        apb(1'b0, 8'h24, 8'h00, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        // Byte lane zero disabled: the write must not land
        pstrb <= 4'hE;
        wr(`ADDR_MODE, 8'h04);
        pstrb <= 4'hF;
        rd(`ADDR_STATUS);
        chk({31'h0, r[4]}, 32'h1);
        $display("test reset done");
    endtask : t_reset

    task t_bufreq;
        wr(`ADDR_TXDATA, 8'h11);
        @(negedge pclk);
        chk(tx_buf_req, 1'b0);
        wr(`ADDR_EXT, 8'h20);
        @(negedge pclk);
        chk(tx_buf_req, 1'b1);
        for (int i = 2; i < 6; i++) wr(`ADDR_TXDATA, 8'(i * 17));
        @(negedge pclk);
        chk(tx_buf_req, 1'b0);
        rd(`ADDR_STATUS);
        chk(r[2:0], 3'h4);
        wr(`ADDR_EXT, 8'h00);
        wr(`ADDR_XMIT, 8'h68);
        st = rx.n;
        wait (rx.n >= st + 56);
        @(negedge pclk);
        chk(tx_buf_req, 1'b1);
        $display("test bufreq done");
    endtask : t_bufreq

    task t_modes;
        wr(`ADDR_MODE, 8'hC0);
        rd(`ADDR_STATUS);
        chk(r[7:4], 4'h1);
        wr(`ADDR_MODE, 8'hF0);
        rd(`ADDR_STATUS);
        chk(r[7:4], 4'hF);
        wr(`ADDR_MODE, 8'h04);
        rd(`ADDR_STATUS);
        chk(r[4], 1'b0);
        wr(`ADDR_SYNC_LO, 8'h16);
        st = rx.n;
        look(64'hFFFFFF, 24);
        $display("test modes done");
    endtask : t_modes

    task t_sync;
        logic [7:0] md[6] = '{8'h00, 8'h00, 8'h10, 8'h30, 8'h30, 8'h10};
        logic [7:0] ln[6] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01};
        logic [63:0] pt[6] = '{64'hE5E5, 64'h965, 64'h2CE52CE5, 64'h965, 64'hE5E5, 64'h965};
        int pl[6] = '{16, 12, 32, 12, 16, 12};
        wr(`ADDR_SYNC_LO, 8'hE5);
        wr(`ADDR_SYNC_HI, 8'h2C);
        for (int k = 0; k < 6; k++) begin
            wr(`ADDR_MODE, md[k]);
            wr(`ADDR_LEN_PRESET, ln[k]);
            st = rx.n;
            look(pt[k], pl[k]);
        end
        $display("test sync done");
    endtask : t_sync

    task t_chars;
        logic [7:0] xc[8] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h48, 8'h28, 8'h68};
        logic [7:0] dt[8] = '{8'h00, 8'h80, 8'hC0, 8'hE0, 8'hF0, 8'h00, 8'h00, 8'h00};
        int nb[8] = '{5, 4, 3, 2, 1, 6, 7, 8};
        wr(`ADDR_MODE, 8'h00);
        wr(`ADDR_LEN_PRESET, 8'h00);
        wr(`ADDR_SYNC_LO, 8'hFF);
        for (int k = 0; k < 8; k++) begin
            wr(`ADDR_XMIT, xc[k]);
            st = rx.n;
            wr(`ADDR_TXDATA, dt[k]);
            look(64'h1 | (64'h1 << (nb[k] + 1)), nb[k] + 2);
        end
        st = rx.n;
        wr(`ADDR_TXDATA, 8'h00);
        wr(`ADDR_TXDATA, 8'h00);
        look(64'h20001, 18);
        wr(`ADDR_MODE, 8'h03);
        st = rx.n;
        wr(`ADDR_TXDATA, 8'hA5);
        look(64'h0A5, 9);
        wr(`ADDR_MODE, 8'h01);
        st = rx.n;
        wr(`ADDR_TXDATA, 8'hA5);
        look(64'h1A5, 9);
        $display("test chars done");
    endtask : t_chars

    task crc_wait(input int b);
        st = rx.n;
        wait (rx.n >= st + b);
        rd(`ADDR_STATUS);
    endtask : crc_wait

    task t_crc;
        wr(`ADDR_MODE, 8'h00);
        wr(`ADDR_SYNC_LO, 8'h16);
        wr(`ADDR_CMD, 8'h80);
        wr(`ADDR_LEN_PRESET, 8'h80);
        wr(`ADDR_XMIT, 8'h6D);
        crc_wait(24);
        chk(r[31:16], 16'h0000);
        wr(`ADDR_CMD, 8'h80);
        crc_wait(24);
        chk(r[31:16], 16'hFFFF);
        wr(`ADDR_TXDATA, 8'h31);
        crc_wait(40);
        chk(r[31:16], crc8(16'hFFFF, 8'h31, 16'h8005));
        wr(`ADDR_XMIT, 8'h6C);
        wr(`ADDR_TXDATA, 8'h55);
        crc_wait(40);
        chk(r[31:16], crc8(16'hFFFF, 8'h31, 16'h8005));
        wr(`ADDR_LEN_PRESET, 8'h00);
        wr(`ADDR_XMIT, 8'h69);
        wr(`ADDR_CMD, 8'h80);
        crc_wait(24);
        chk(r[31:16], 16'h0000);
        wr(`ADDR_TXDATA, 8'h31);
        crc_wait(40);
        chk(r[31:16], crc8(16'h0000, 8'h31, 16'h1021));
        $display("test crc done");
    endtask : t_crc

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        errors = 0;
        checks = 0;
        cyc = 0;
        st = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_bufreq;
        t_modes;
        t_sync;
        t_chars;
        t_crc;
        wrap_up;
    end
endmodule : testbench
